// ### core/ils_pkg.sv
// Constants for the I/O extension module status indicator logic.
// Assumes a single 100 MHz system clock and an active-high async reset.
//
// Notes on behaviour
// [R1] All three lamps steady during self-test
// [R2] Ready, no exchange: green flashes only
// [R3] Link lost: relays off, green flash, red
// [R4] Exchange, no diagnosis: green steady only
// [R5] Exchange with diagnosis: green, yellow flashes
// [R6] Hardware defect: red flashes, overrides all
// [R7] Host parameters applied automatically after link
// [R8] Common 2 Hz 50 percent blink
package ils_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_FREQ_HZ = 100_000_000; // System clock rate
  localparam int unsigned BLINK_FREQ_HZ = 2; // Blink rate
  // Half period in cycles (toggle point of the blink)
  localparam int unsigned BLINK_HALF_CYC = CLK_FREQ_HZ / (2 * BLINK_FREQ_HZ);
  localparam int unsigned BLINK_CNT_W = 25; // Width of blink counter
  localparam logic [BLINK_CNT_W-1:0] BLINK_LAST =
    BLINK_CNT_W'(BLINK_HALF_CYC - 1); // Last count of a half period

  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int unsigned RELAY_W = 4; // Relay outputs
  localparam int unsigned PARAM_W = 16; // Parameter word width
  localparam int unsigned PARAM_N = 8; // Parameter words held
  localparam int unsigned PADDR_W = 3; // Parameter index width
  localparam logic [RELAY_W-1:0] RELAY_OFF = 4'h0; // All relays open
  localparam logic [PARAM_W-1:0] PARAM_RST = 16'h0000; // Parameter reset value

  // Operating states
  typedef enum logic [2:0] {
    ILS_SELFTEST,
    ILS_READY,
    ILS_EXCHANGE,
    ILS_LINK_LOST,
    ILS_DEFECT
  } ils_state_t;

endpackage : ils_pkg

// ### core/ils_status.sv
// Status tracking, indicator drive, relay gating and parameter store.
// Assumes host link events arrive as synchronous levels from the link layer.
`timescale 1ns/1ps
`default_nettype none
module ils_status (
  input wire logic sys_clk_in, // System clock
  input wire logic rst_in, // Async reset, active high
  input wire logic selftest_done_in, // Self-test finished, level
  input wire logic hw_defect_in, // Internal defect detected, level
  input wire logic link_up_in, // Cyclic exchange running, level
  input wire logic diag_pending_in, // Any diagnosis pending, level
  input wire logic [ils_pkg::RELAY_W-1:0] relay_cmd_in, // Relay command from host
  input wire logic param_we_in, // Parameter write strobe from host
  input wire logic [ils_pkg::PADDR_W-1:0] param_addr_in, // Parameter index
  input wire logic [ils_pkg::PARAM_W-1:0] param_data_in, // Parameter value
  output logic led_green_out, // Green lamp, high = lit
  output logic led_yellow_out, // Yellow lamp, high = lit
  output logic led_red_out, // Red lamp, high = lit
  output logic [ils_pkg::RELAY_W-1:0] relay_out, // Relay drive
  output logic params_valid_out, // Parameters received since link up
  output logic [ils_pkg::PARAM_W*ils_pkg::PARAM_N-1:0] params_out // Applied parameters
);
  import ils_pkg::*;

  // ----------------------------------------
  // Blink divider
  // ----------------------------------------
  logic [BLINK_CNT_W-1:0] blink_cnt; // Half period counter
  logic [BLINK_CNT_W-1:0] next_blink_cnt; // Next count
  logic blink; // Blink phase
  logic next_blink; // Next phase

  // Count half periods, toggle phase
  always_comb
  begin
    next_blink_cnt = blink_cnt + 1'b1;
    next_blink = blink;
    // [R8] Common blink divider
    if (blink_cnt == BLINK_LAST)
    begin
      next_blink_cnt = '0;
      next_blink = ~blink;
    end
  end

  // Divider registers
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      blink_cnt <= '0;
      blink <= 1'b0;
    end
    else
    begin
      blink_cnt <= next_blink_cnt;
      blink <= next_blink;
    end
  end

  // ----------------------------------------
  // Operating state
  // ----------------------------------------
  ils_state_t state; // Current state
  ils_state_t next_state; // Next state

  // State transitions
  always_comb
  begin
    next_state = state;
    unique case (state)
      ILS_SELFTEST:
      begin
        if (selftest_done_in)
          next_state = ILS_READY;
      end
      ILS_READY:
      begin
        if (link_up_in)
          next_state = ILS_EXCHANGE;
      end
      ILS_EXCHANGE:
      begin
        if (!link_up_in)
          next_state = ILS_LINK_LOST;
      end
      ILS_LINK_LOST:
      begin
        if (link_up_in)
          next_state = ILS_EXCHANGE;
      end
      ILS_DEFECT:
      begin
        next_state = ILS_DEFECT; // Held until reset
      end
    endcase
    // [R6] Defect overrides all
    if (hw_defect_in)
      next_state = ILS_DEFECT;
  end

  // State register
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
      state <= ILS_SELFTEST;
    else
      state <= next_state;
  end

  // ----------------------------------------
  // Lamps and relays
  // ----------------------------------------
  logic next_green; // Next green
  logic next_yellow; // Next yellow
  logic next_red; // Next red
  logic [RELAY_W-1:0] next_relay; // Next relay drive

  // Decode lamps and relays from next state
  always_comb
  begin
    next_green = 1'b0;
    next_yellow = 1'b0;
    next_red = 1'b0;
    next_relay = RELAY_OFF;
    unique case (next_state)
      // [R1] Self-test all on
      ILS_SELFTEST:
      begin
        next_green = 1'b1;
        next_yellow = 1'b1;
        next_red = 1'b1;
      end
      // [R2] Ready green flashes
      ILS_READY:
      begin
        next_green = next_blink;
      end
      // [R4] [R5] Exchange lamps and relays
      ILS_EXCHANGE:
      begin
        next_green = 1'b1;
        next_yellow = diag_pending_in & next_blink;
        next_relay = relay_cmd_in;
      end
      // [R3] Link lost relays off
      ILS_LINK_LOST:
      begin
        next_green = next_blink;
        next_red = 1'b1;
      end
      // [R6] Defect red flashes
      ILS_DEFECT:
      begin
        next_red = next_blink;
      end
    endcase
  end

  // Output registers
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      led_green_out <= 1'b1;
      led_yellow_out <= 1'b1;
      led_red_out <= 1'b1;
      relay_out <= RELAY_OFF;
    end
    else
    begin
      led_green_out <= next_green;
      led_yellow_out <= next_yellow;
      led_red_out <= next_red;
      relay_out <= next_relay;
    end
  end

  // ----------------------------------------
  // Parameter store
  // ----------------------------------------
  logic [PARAM_W-1:0] param_mem [PARAM_N]; // Stored parameters
  logic [PARAM_W-1:0] next_param_mem [PARAM_N]; // Next values
  logic next_params_valid; // Next valid flag
  logic accept; // Host write accepted

  // [R7] Accept host download
  assign accept = param_we_in && (state == ILS_EXCHANGE) && link_up_in;

  // Next parameter values and valid flag
  always_comb
  begin
    next_param_mem = param_mem;
    next_params_valid = params_valid_out;
    if (accept)
    begin
      next_param_mem[param_addr_in] = param_data_in;
      next_params_valid = 1'b1;
    end
    else if (state != ILS_EXCHANGE)
      next_params_valid = 1'b0;
  end

  // Parameter registers, one per entry
  genvar gi;
  generate
    for (gi = 0; gi < PARAM_N; gi++)
    begin : g_param
      always_ff @(posedge sys_clk_in or posedge rst_in)
      begin
        if (rst_in)
          param_mem[gi] <= PARAM_RST;
        else
          param_mem[gi] <= next_param_mem[gi];
      end
      assign params_out[gi*PARAM_W +: PARAM_W] = param_mem[gi];
    end
  endgenerate

  // Valid flag register
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
      params_valid_out <= 1'b0;
    else
      params_valid_out <= next_params_valid;
  end

endmodule : ils_status
`default_nettype wire

// ### verif/ils_status_chk.sv
// Assertions on the status indicator ports.
// Assumes binding onto ils_status.
`timescale 1ns/1ps
`default_nettype none
module ils_status_chk (
  input wire logic sys_clk_in, // Clock
  input wire logic rst_in, // Reset
  input wire logic selftest_done_in, // Self-test over
  input wire logic hw_defect_in, // Defect
  input wire logic link_up_in, // Link up
  input wire logic diag_pending_in, // Diagnosis
  input wire logic [ils_pkg::RELAY_W-1:0] relay_cmd_in, // Relay command
  input wire logic param_we_in, // Write strobe
  input wire logic [ils_pkg::PADDR_W-1:0] param_addr_in, // Index
  input wire logic [ils_pkg::PARAM_W-1:0] param_data_in, // Value
  input wire logic led_green_out, // Green
  input wire logic led_yellow_out, // Yellow
  input wire logic led_red_out, // Red
  input wire logic [ils_pkg::RELAY_W-1:0] relay_out, // Relays
  input wire logic params_valid_out, // Valid
  input wire logic [ils_pkg::PARAM_W*ils_pkg::PARAM_N-1:0] params_out // Words
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // Exchange running, then the link drops
  sequence s_drop;
    led_green_out && !led_red_out && !hw_defect_in ##1 !link_up_in && !hw_defect_in;
  endsequence
  AST_ST: assert property (
    !selftest_done_in && !hw_defect_in |=> led_green_out && led_yellow_out && led_red_out)
    else $error("self-test lamps wrong");
  AST_RDY: assert property (
    $rose(selftest_done_in) && !link_up_in && !hw_defect_in
    |=> !led_green_out && !led_yellow_out && !led_red_out) else $error("ready lamps wrong");
  AST_LOST: assert property (
    s_drop |=> led_red_out && !led_yellow_out && relay_out == 4'h0) else $error("link lost");
  AST_ROFF: assert property (
    !link_up_in |=> relay_out == 4'h0) else $error("relays on without link");
  AST_EXC: assert property (
    selftest_done_in && link_up_in && !led_red_out && !diag_pending_in && !hw_defect_in
    |=> led_green_out && !led_yellow_out && !led_red_out) else $error("exchange lamps");
  AST_RON: assert property (
    selftest_done_in && link_up_in && !led_red_out && !hw_defect_in
    |=> relay_out == $past(relay_cmd_in)) else $error("relay not passed");
  AST_DIAG: assert property (
    selftest_done_in && link_up_in && !led_red_out && diag_pending_in && !hw_defect_in
    |=> led_green_out && !led_red_out) else $error("diagnosis lamps");
  AST_DEF: assert property (
    hw_defect_in |=> !led_green_out && !led_yellow_out && relay_out == 4'h0)
    else $error("defect lamps");
  AST_PRM: assert property (
    param_we_in && link_up_in && led_green_out && !led_red_out && !hw_defect_in
    |=> params_valid_out && params_out[{$past(param_addr_in), 4'h0} +: 16]
    == $past(param_data_in)) else $error("parameter not applied");
endmodule : ils_status_chk
bind ils_status ils_status_chk u_chk (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
  .selftest_done_in(selftest_done_in), .hw_defect_in(hw_defect_in), .link_up_in(link_up_in),
  .diag_pending_in(diag_pending_in), .relay_cmd_in(relay_cmd_in), .param_we_in(param_we_in),
  .param_addr_in(param_addr_in), .param_data_in(param_data_in),
  .led_green_out(led_green_out), .led_yellow_out(led_yellow_out), .led_red_out(led_red_out),
  .relay_out(relay_out), .params_valid_out(params_valid_out), .params_out(params_out));
`default_nettype wire

// ### verif/ils_host.sv
// Host controller model: link, relay command, parameter download.
// Assumes the bench raises link_en_in to bring the link up.
`timescale 1ns/1ps
`default_nettype none
module ils_host (
  input wire logic sys_clk_in, // Clock
  input wire logic link_en_in, // Link wanted
  output logic link_up_out, // Link running
  output logic [ils_pkg::RELAY_W-1:0] relay_cmd_out, // Relay command
  output logic param_we_out, // Write strobe
  output logic [ils_pkg::PADDR_W-1:0] param_addr_out, // Index
  output logic [ils_pkg::PARAM_W-1:0] param_data_out // Value
);
  import ils_pkg::*;
  logic [3:0] idx; // Next word to send
  initial
  begin
    {link_up_out, relay_cmd_out, param_we_out, param_addr_out, param_data_out} = '0;
    idx = 4'h0;
  end
  // download every word once the link is up
  always @(negedge sys_clk_in)
  begin
    link_up_out <= link_en_in;
    relay_cmd_out <= link_en_in ? 4'h9 : 4'h0;
    param_we_out <= 1'b0;
    param_data_out <= ~param_data_out; // Idle bus keeps moving
    if (!link_en_in)
      idx <= 4'h0;
    else if (link_up_out && idx < 4'h8)
    begin
      param_we_out <= 1'b1;
      param_addr_out <= idx[2:0];
      param_data_out <= 16'h00A0 + {12'h000, idx};
      idx <= idx + 4'h1;
    end
  end
endmodule : ils_host
`default_nettype wire

// ### verif/ils_status_test.sv
// Bench for the status indicator block with a host model.
// Assumes the blink phase stays off for the whole short run.
`timescale 1ns/1ps
`default_nettype none
module ils_status_test;
  import ils_pkg::*;
  logic sys_clk_in, rst_in, done, defect, diag, link_en, link_up, we, g, y, r, valid;
  logic [RELAY_W-1:0] cmd, relay;
  logic [PADDR_W-1:0] addr;
  logic [PARAM_W-1:0] data;
  logic [PARAM_W*PARAM_N-1:0] params;
  int num_errors = 0;
  int samples_checked = 0;
  ils_host HOST (.sys_clk_in(sys_clk_in), .link_en_in(link_en), .link_up_out(link_up),
    .relay_cmd_out(cmd), .param_we_out(we), .param_addr_out(addr), .param_data_out(data));
  ils_status DUT (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .selftest_done_in(done),
    .hw_defect_in(defect), .link_up_in(link_up), .diag_pending_in(diag),
    .relay_cmd_in(cmd), .param_we_in(we), .param_addr_in(addr), .param_data_in(data),
    .led_green_out(g), .led_yellow_out(y), .led_red_out(r), .relay_out(relay),
    .params_valid_out(valid), .params_out(params));
  initial
  begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up;
    if (num_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask : cyc
  task automatic t_ready;
    cyc(4);
    check({g, y, r, relay, valid}, 8'hE0);
    done = 1'b1;
    cyc(2);
    check({g, y, r, relay}, 7'h00);
  endtask : t_ready
  task automatic t_exchange;
    int i;
    link_en = 1'b1;
    for (i = 0; i < 20 && valid !== 1'b1; i++)
      cyc(1);
    if (valid !== 1'b1)
    begin
      num_errors++;
      wrap_up();
    end
    cyc(10);
    check({g, y, r, relay}, 7'h49);
    for (i = 0; i < 8; i++)
      check(params[16*i +: 16], 16'h00A0 + i);
    diag = 1'b1;
    cyc(2);
    check({g, r}, 2'h2);
    diag = 1'b0;
  endtask : t_exchange
  task automatic t_lost;
    link_en = 1'b0;
    cyc(3);
    check({g, y, r, relay, valid}, 8'h20);
    link_en = 1'b1;
    cyc(3);
    check({g, y, r}, 3'h4);
  endtask : t_lost
  task automatic t_defect;
    link_en = 1'b0;
    cyc(3);
    defect = 1'b1;
    cyc(2);
    defect = 1'b0;
    cyc(3);
    check({g, y, r, relay}, 7'h00);
  endtask : t_defect
  initial
  begin
    {rst_in, done, defect, diag, link_en} = 5'h10;
    cyc(3);
    rst_in = 1'b0;
    t_ready();
    t_exchange();
    t_lost();
    t_defect();
    wrap_up();
  end
endmodule : ils_status_test
`default_nettype wire
